// File: shared/pcb_consts.svh
`ifndef PCB_CONSTS_SVH
`define PCB_CONSTS_SVH
// ----------------------------------------------------------------------
// Configuration offsets (byte addresses, dword decoded)
// ----------------------------------------------------------------------
`define PCB_OFS_MSG_CTL 8'h52
`define PCB_OFS_MSG_ADDR_LO 8'h54
`define PCB_OFS_MSG_ADDR_HI 8'h58
`define PCB_OFS_MSG_DATA 8'h5c
`define PCB_OFS_CLK_EN 8'hd8
`define PCB_OFS_IRQ_EDGE 8'he2
`define PCB_OFS_IRQ_STAT 8'he4
// ----------------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------------
`define PCB_MC_EN_POS 16
`define PCB_MC_MM_LSB 20
`define PCB_MC_MM_MSB 22
`define PCB_CLK_EN_RST 7'h7f
`define PCB_EDGE_RST 16'h0000
// ----------------------------------------------------------------------
// Clock timing (half periods in ps, core clock 125 MHz)
// ----------------------------------------------------------------------
`define PCB_CLK_PERIOD_PS 8000
`define PCB_HALF_PS_66 7576
`define PCB_HALF_PS_33 15152
`define PCB_HALF_PS_50 10000
`define PCB_HALF_PS_25 20000
`define PCB_HALF_CYC(ps) \
  ((((ps) + `PCB_CLK_PERIOD_PS / 2) / `PCB_CLK_PERIOD_PS) < 1 ? 1 : \
   (((ps) + `PCB_CLK_PERIOD_PS / 2) / `PCB_CLK_PERIOD_PS))
`endif

// File: shared/pcb_pkg.sv
package pcb_pkg;
  // ----------------------------------------------------------------------
  // Message sender states
  // ----------------------------------------------------------------------
  typedef enum logic [0:0] {
    PCB_IDLE = 1'b0,
    PCB_SEND = 1'b1
  } pcb_arb_e;
endpackage

// File: shared/pcb_irq_if.sv
`timescale 1ns/1ns
// ----------------------------------------------------------------------
// Interrupt detector to core link
// ----------------------------------------------------------------------
interface pcb_irq_if;
  logic [15:0] evt_tgl;
  logic [15:0] level_status;
  logic [15:0] edge_mode;
  // Detector side runs on the PCI clock input
  modport det (output evt_tgl, output level_status, input edge_mode);
  // Core side runs on the core clock
  modport core (input evt_tgl, input level_status, output edge_mode);
endinterface

// File: verilog/pcb_clkgen.sv
`timescale 1ns/1ns
module pcb_clkgen (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Control
  input wire logic [2:0] half_cnt,
  input wire logic [6:0] clk_en,
  // Generated clocks
  output logic [6:0] clk_out
);
  logic [2:0] cnt_ff;
  logic phase_ff;
  logic [6:0] act_ff;
  logic [6:0] out_ff;
  wire wrap = (cnt_ff >= 3'(half_cnt - 3'h1));
  wire nxt_phase = wrap ? ~phase_ff : phase_ff;
  wire rise = wrap & ~phase_ff;
  wire [2:0] nxt_cnt = wrap ? 3'h0 : 3'(cnt_ff + 3'h1);

  // Shared divider; >= compare survives a rate change mid count
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_ff <= 3'h0;
      phase_ff <= 1'b0;
    end else begin
      cnt_ff <= nxt_cnt;
      phase_ff <= nxt_phase;
    end
  end

  // ----------------------------------------------------------------------
  // Per output gating
  // ----------------------------------------------------------------------
  genvar i;
  generate
    for (i = 0; i < 7; i++) begin : g_out
      wire nxt_act = rise ? clk_en[i] : act_ff[i];
      // Enable only changes while low, so no runt pulse escapes
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          act_ff[i] <= 1'b1;
          out_ff[i] <= 1'b0;
        end else begin
          act_ff[i] <= nxt_act;
          out_ff[i] <= nxt_phase & nxt_act;
        end
      end
      whole_high_a: assert property (@(posedge clk)
        disable iff (!rst_n) out_ff[i] |-> phase_ff)
        else $error("clock high off phase");
      whole_low_a: assert property (@(posedge clk)
        disable iff (!rst_n) $fell(out_ff[i]) |-> !phase_ff)
        else $error("clock cut short");
    end
  endgenerate

  assign clk_out = out_ff;
endmodule

// File: verilog/pcb_irq_detect.sv
`timescale 1ns/1ns
module pcb_irq_detect (
  // PCI clock input domain
  input wire logic pci_clk,
  input wire logic rst_n,
  // Decoded serial interrupt pins
  input wire logic [15:0] irq_sample_pin,
  input wire logic irq_frame_pin,
  // Link to the core
  pcb_irq_if.det link
);
  logic rs1_ff;
  logic rs2_ff;
  logic [15:0] smp_s1_ff;
  logic [15:0] smp_s2_ff;
  logic fr_s1_ff;
  logic fr_s2_ff;
  logic fr_s3_ff;
  logic [15:0] edg_s1_ff;
  logic [15:0] edg_s2_ff;
  logic [15:0] phase_ff;
  logic [15:0] lvl_ff;
  logic [15:0] tgl_ff;
  wire prst_n = rs2_ff;

  // Reset release retimed into the PCI clock domain
  always_ff @(posedge pci_clk or negedge rst_n) begin
    if (!rst_n) begin
      rs1_ff <= 1'b0;
      rs2_ff <= 1'b0;
    end else begin
      rs1_ff <= 1'b1;
      rs2_ff <= rs1_ff;
    end
  end

  // Pin and mode synchronisers; first stages feed only second stages
  always_ff @(posedge pci_clk or negedge prst_n) begin
    if (!prst_n) begin
      smp_s1_ff <= 16'h0000;
      smp_s2_ff <= 16'h0000;
      fr_s1_ff <= 1'b0;
      fr_s2_ff <= 1'b0;
      fr_s3_ff <= 1'b0;
      edg_s1_ff <= 16'h0000;
      edg_s2_ff <= 16'h0000;
    end else begin
      smp_s1_ff <= irq_sample_pin;
      smp_s2_ff <= smp_s1_ff;
      fr_s1_ff <= irq_frame_pin;
      fr_s2_ff <= fr_s1_ff;
      fr_s3_ff <= fr_s2_ff;
      edg_s1_ff <= link.edge_mode;
      edg_s2_ff <= edg_s1_ff;
    end
  end

  // ----------------------------------------------------------------------
  // Event detection
  // ----------------------------------------------------------------------
  wire fr_rise = fr_s2_ff & ~fr_s3_ff;
  wire [15:0] edge_evt = {16{fr_rise}} & smp_s2_ff & ~phase_ff & edg_s2_ff;
  wire [15:0] lvl_evt = smp_s2_ff & ~lvl_ff & ~edg_s2_ff;
  wire [15:0] nxt_phase = fr_rise ? smp_s2_ff : phase_ff;

  // Events become toggles so the core can catch every one
  always_ff @(posedge pci_clk or negedge prst_n) begin
    if (!prst_n) begin
      phase_ff <= 16'h0000;
      lvl_ff <= 16'h0000;
      tgl_ff <= 16'h0000;
    end else begin
      phase_ff <= nxt_phase;
      lvl_ff <= smp_s2_ff;
      tgl_ff <= tgl_ff ^ edge_evt ^ lvl_evt;
    end
  end

  assign link.evt_tgl = tgl_ff;
  assign link.level_status = lvl_ff;

  lvl_event_a: assert property (@(posedge pci_clk)
    disable iff (!prst_n) (|lvl_evt) |=> tgl_ff != $past(tgl_ff))
    else $error("level rise lost");
  edge_quiet_a: assert property (@(posedge pci_clk)
    disable iff (!prst_n) (!fr_rise && !(|lvl_evt)) |=> $stable(tgl_ff))
    else $error("spurious interrupt event");
endmodule

// File: verilog/pcb_top.sv
// Operation
// - Interrupt n uses message n modulo enabled count; one message means zero.
// - Each message leaves as a memory write, 32 or 64 bit address form.
// - Message data and message number fill the first two payload bytes.
// - Seven clock outputs, one clock input, up to six bus devices.
// - Range select high: 66 MHz with speed enable high, else 33 MHz.
// - Range select low: 50 MHz with speed enable high, else 25 MHz.
// - Seven enable bits gate outputs individually; all enabled after reset.
// - Interrupt detection runs from the clock input pin; bus logic runs from the core clock.
// - Message count field selects 1 to 16 messages in powers of two.
// - Messages go only with message enable set; count from 3-bit field.
// - Edge mode sends on sample rise; level mode on status rise.
`timescale 1ns/1ns
`include "pcb_consts.svh"
module pcb_top (
  // Core clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // PCI clock input and straps
  input wire logic pci_clk,
  input wire logic clock_range_select,
  input wire logic fast_speed_enable,
  // Serial interrupt samples
  input wire logic [15:0] irq_sample_pin,
  input wire logic irq_frame_pin,
  // Configuration access
  input wire logic [7:0] cfg_addr,
  input wire logic [3:0] cfg_be,
  input wire logic cfg_wr,
  input wire logic cfg_rd,
  input wire logic [31:0] cfg_wdata,
  output logic [31:0] cfg_rdata,
  output logic cfg_rvalid,
  // Upstream memory write requests
  output logic msi_req_valid,
  input wire logic msi_req_ready,
  output logic msi_req_addr64,
  output logic [63:0] msi_req_addr,
  output logic [31:0] msi_req_data,
  // Generated PCI clocks
  output logic [6:0] generated_clock_outputs
);
  // ----------------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------------
  localparam logic [2:0] HALF_66 = 3'(`PCB_HALF_CYC(`PCB_HALF_PS_66));
  localparam logic [2:0] HALF_33 = 3'(`PCB_HALF_CYC(`PCB_HALF_PS_33));
  localparam logic [2:0] HALF_50 = 3'(`PCB_HALF_CYC(`PCB_HALF_PS_50));
  localparam logic [2:0] HALF_25 = 3'(`PCB_HALF_CYC(`PCB_HALF_PS_25));
  localparam logic [5:0] DW_MSG_CTL = 6'(`PCB_OFS_MSG_CTL >> 2);
  localparam logic [5:0] DW_ADDR_LO = 6'(`PCB_OFS_MSG_ADDR_LO >> 2);
  localparam logic [5:0] DW_ADDR_HI = 6'(`PCB_OFS_MSG_ADDR_HI >> 2);
  localparam logic [5:0] DW_DATA = 6'(`PCB_OFS_MSG_DATA >> 2);
  localparam logic [5:0] DW_CLK_EN = 6'(`PCB_OFS_CLK_EN >> 2);
  localparam logic [5:0] DW_EDGE = 6'(`PCB_OFS_IRQ_EDGE >> 2);
  localparam logic [5:0] DW_STAT = 6'(`PCB_OFS_IRQ_STAT >> 2);

  logic rng_s1_ff;
  logic rng_s2_ff;
  logic fast_s1_ff;
  logic fast_s2_ff;
  logic [15:0] tg_s1_ff;
  logic [15:0] tg_s2_ff;
  logic [15:0] tg_s3_ff;
  logic [15:0] st_s1_ff;
  logic [15:0] st_s2_ff;
  logic msg_en_ff;
  logic [2:0] msg_mm_ff;
  logic [31:2] addr_lo_ff;
  logic [31:0] addr_hi_ff;
  logic [15:0] msg_data_ff;
  logic [6:0] clk_en_ff;
  logic [15:0] edge_ff;
  logic [31:0] rdata_ff;
  logic rvalid_ff;
  logic [15:0] pend_ff;
  pcb_pkg::pcb_arb_e st_ff;
  pcb_pkg::pcb_arb_e nxt_st;
  logic req_valid_ff;
  logic req_64_ff;
  logic [63:0] req_addr_ff;
  logic [31:0] req_data_ff;

  pcb_irq_if irq_link ();

  // Byte lane merge for configuration writes
  function automatic logic [31:0] mrg(input logic [31:0] old,
                                      input logic [31:0] wd,
                                      input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        r[b*8 +: 8] = wd[b*8 +: 8];
      end
    end
    return r;
  endfunction

  // Lowest pending interrupt wins the next message slot
  function automatic logic [3:0] lowest(input logic [15:0] v);
    logic [3:0] r;
    r = 4'h0;
    for (int k = 15; k >= 0; k--) begin
      if (v[k]) begin
        r = 4'(k);
      end
    end
    return r;
  endfunction

  // ----------------------------------------------------------------------
  // Synchronisers
  // ----------------------------------------------------------------------
  // Straps and detector outputs are levels or toggles, two stages each
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rng_s1_ff <= 1'b0;
      rng_s2_ff <= 1'b0;
      fast_s1_ff <= 1'b0;
      fast_s2_ff <= 1'b0;
      tg_s1_ff <= 16'h0000;
      tg_s2_ff <= 16'h0000;
      tg_s3_ff <= 16'h0000;
      st_s1_ff <= 16'h0000;
      st_s2_ff <= 16'h0000;
    end else begin
      rng_s1_ff <= clock_range_select;
      rng_s2_ff <= rng_s1_ff;
      fast_s1_ff <= fast_speed_enable;
      fast_s2_ff <= fast_s1_ff;
      tg_s1_ff <= irq_link.evt_tgl;
      tg_s2_ff <= tg_s1_ff;
      tg_s3_ff <= tg_s2_ff;
      st_s1_ff <= irq_link.level_status;
      st_s2_ff <= st_s1_ff;
    end
  end

  // ----------------------------------------------------------------------
  // Clock generation
  // ----------------------------------------------------------------------
  // The 125 MHz core only approximates these rates; a PLL tap would fix it
  wire [2:0] half_fast = fast_s2_ff ? HALF_66 : HALF_33;
  wire [2:0] half_slow = fast_s2_ff ? HALF_50 : HALF_25;
  wire [2:0] half_cnt = rng_s2_ff ? half_fast : half_slow;

  // Output 6 is the one the board loops back to the clock input
  pcb_clkgen u_clkgen (
    .clk(clk),
    .rst_n(rst_n),
    .half_cnt(half_cnt),
    .clk_en(clk_en_ff),
    .clk_out(generated_clock_outputs)
  );

  // Interrupt detection runs on the looped or external clock input
  pcb_irq_detect u_irq (
    .pci_clk(pci_clk),
    .rst_n(rst_n),
    .irq_sample_pin(irq_sample_pin),
    .irq_frame_pin(irq_frame_pin),
    .link(irq_link)
  );

  // ----------------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------------
  wire [5:0] dw = cfg_addr[7:2];
  wire [31:0] mc_old = 32'({msg_mm_ff, 3'h0, msg_en_ff}) << `PCB_MC_EN_POS;
  wire [31:0] mc_w = mrg(mc_old, cfg_wdata, cfg_be);
  wire [31:0] lo_w = mrg({addr_lo_ff, 2'b00}, cfg_wdata, cfg_be);
  wire [31:0] hi_w = mrg(addr_hi_ff, cfg_wdata, cfg_be);
  wire [31:0] dat_w = mrg({16'h0000, msg_data_ff}, cfg_wdata, cfg_be);
  wire [31:0] ce_w = mrg({25'h0, clk_en_ff}, cfg_wdata, cfg_be);
  wire [31:0] edg_w = mrg({edge_ff, 16'h0000}, cfg_wdata, cfg_be);
  wire wr_mc = cfg_wr && dw == DW_MSG_CTL;
  wire wr_lo = cfg_wr && dw == DW_ADDR_LO;
  wire wr_hi = cfg_wr && dw == DW_ADDR_HI;
  wire wr_dat = cfg_wr && dw == DW_DATA;
  wire wr_ce = cfg_wr && dw == DW_CLK_EN;
  wire wr_edg = cfg_wr && dw == DW_EDGE;

  // Writes honour byte enables; reserved bits are dropped
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      msg_en_ff <= 1'b0;
      msg_mm_ff <= 3'h0;
      addr_lo_ff <= 30'h0;
      addr_hi_ff <= 32'h0;
      msg_data_ff <= 16'h0000;
      clk_en_ff <= `PCB_CLK_EN_RST;
      edge_ff <= `PCB_EDGE_RST;
    end else begin
      if (wr_mc) begin
        msg_en_ff <= mc_w[`PCB_MC_EN_POS];
        msg_mm_ff <= mc_w[`PCB_MC_MM_MSB:`PCB_MC_MM_LSB];
      end
      if (wr_lo) addr_lo_ff <= lo_w[31:2];
      if (wr_hi) addr_hi_ff <= hi_w;
      if (wr_dat) msg_data_ff <= dat_w[15:0];
      if (wr_ce) clk_en_ff <= ce_w[6:0];
      if (wr_edg) edge_ff <= edg_w[31:16];
    end
  end

  assign irq_link.edge_mode = edge_ff;

  // Read mux; unmapped dwords read as zero
  wire [31:0] rd_mux =
    (dw == DW_MSG_CTL) ? mc_old :
    (dw == DW_ADDR_LO) ? {addr_lo_ff, 2'b00} :
    (dw == DW_ADDR_HI) ? addr_hi_ff :
    (dw == DW_DATA) ? {16'h0000, msg_data_ff} :
    (dw == DW_CLK_EN) ? {25'h0, clk_en_ff} :
    (dw == DW_EDGE) ? {edge_ff, 16'h0000} :
    (dw == DW_STAT) ? {16'h0000, st_s2_ff} : 32'h0;

  // Read data lands one cycle after the strobe and holds
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_ff <= 32'h0;
      rvalid_ff <= 1'b0;
    end else begin
      rvalid_ff <= cfg_rd;
      if (cfg_rd) rdata_ff <= rd_mux;
    end
  end

  // ----------------------------------------------------------------------
  // Message generation
  // ----------------------------------------------------------------------
  // Count field 0..4 gives 1..16 messages; reserved codes act as 16
  wire [3:0] msg_mask = (msg_mm_ff == 3'h0) ? 4'h0 :
                        (msg_mm_ff == 3'h1) ? 4'h1 :
                        (msg_mm_ff == 3'h2) ? 4'h3 :
                        (msg_mm_ff == 3'h3) ? 4'h7 : 4'hf;
  wire [15:0] evt = tg_s2_ff ^ tg_s3_ff;
  wire launch = st_ff == pcb_pkg::PCB_IDLE && msg_en_ff && |pend_ff;
  wire [3:0] sel_idx = lowest(pend_ff);
  wire [3:0] launch_num = sel_idx & msg_mask;
  wire [15:0] clr = launch ? 16'(16'h1 << sel_idx) : 16'h0000;
  // Set beats clear; events are dropped while messages are disabled
  wire [15:0] nxt_pend = ((pend_ff & ~clr) | evt) & {16{msg_en_ff}};
  wire [15:0] pay_lo = {msg_data_ff[15:4],
                        (msg_data_ff[3:0] & ~msg_mask) | launch_num};
  wire addr64 = addr_hi_ff != 32'h0;

  // Sender walks idle to send and back on acceptance
  always_comb begin
    nxt_st = st_ff;
    case (st_ff)
      pcb_pkg::PCB_IDLE: begin
        if (launch) nxt_st = pcb_pkg::PCB_SEND;
      end
      pcb_pkg::PCB_SEND: begin
        if (msi_req_ready) nxt_st = pcb_pkg::PCB_IDLE;
      end
      default: nxt_st = pcb_pkg::PCB_IDLE;
    endcase
  end

  // Request fields load at launch and hold until accepted
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_ff <= pcb_pkg::PCB_IDLE;
      pend_ff <= 16'h0000;
      req_valid_ff <= 1'b0;
      req_64_ff <= 1'b0;
      req_addr_ff <= 64'h0;
      req_data_ff <= 32'h0;
    end else begin
      st_ff <= nxt_st;
      pend_ff <= nxt_pend;
      req_valid_ff <= nxt_st == pcb_pkg::PCB_SEND;
      if (launch) begin
        req_64_ff <= addr64;
        req_addr_ff <= {addr_hi_ff, addr_lo_ff, 2'b00};
        req_data_ff <= {16'h0000, pay_lo};
      end
    end
  end

  assign cfg_rdata = rdata_ff;
  assign cfg_rvalid = rvalid_ff;
  assign msi_req_valid = req_valid_ff;
  assign msi_req_addr64 = req_64_ff;
  assign msi_req_addr = req_addr_ff;
  assign msi_req_data = req_data_ff;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  alias_map_a: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(req_valid_ff) |-> (req_data_ff[3:0] & $past(msg_mask)) ==
      ($past(sel_idx) & $past(msg_mask)))
    else $error("message number not aliased");
  single_msg_a: assert property (@(posedge clk) disable iff (!rst_n)
    (launch && msg_mm_ff == 3'h0) |=> req_data_ff[3:0] ==
      $past(msg_data_ff[3:0]))
    else $error("single message not zero");
  addr_form_a: assert property (@(posedge clk) disable iff (!rst_n)
    req_valid_ff |-> req_64_ff == (req_addr_ff[63:32] != 32'h0))
    else $error("address form mismatch");
  req_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
    (req_valid_ff && !msi_req_ready) |=> req_valid_ff &&
      $stable(req_addr_ff) && $stable(req_data_ff))
    else $error("request dropped before accept");
  payload_hi_a: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(req_valid_ff) |-> req_data_ff[15:4] == $past(msg_data_ff[15:4]) &&
      req_data_ff[31:16] == 16'h0000)
    else $error("payload bytes wrong");
  send_gate_a: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(req_valid_ff) |-> $past(msg_en_ff))
    else $error("message sent while disabled");
  rate_fast_a: assert property (@(posedge clk) disable iff (!rst_n)
    rng_s2_ff |-> half_cnt == (fast_s2_ff ? HALF_66 : HALF_33))
    else $error("high range rate wrong");
  rate_slow_a: assert property (@(posedge clk) disable iff (!rst_n)
    !rng_s2_ff |-> half_cnt == (fast_s2_ff ? HALF_50 : HALF_25))
    else $error("low range rate wrong");
  en_write_a: assert property (@(posedge clk) disable iff (!rst_n)
    (cfg_wr && dw == DW_CLK_EN && cfg_be[0]) |=>
      clk_en_ff == $past(cfg_wdata[6:0]))
    else $error("clock enable write lost");
endmodule

// File: sim/pcb_up_model.sv
`timescale 1ns/1ns
// ----------------------------------------------------------------------
// Upstream sink for memory write requests
// ----------------------------------------------------------------------
module pcb_up_model (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Request from the block
  input wire logic valid,
  input wire logic addr64,
  input wire logic [63:0] addr,
  input wire logic [31:0] data,
  output logic ready,
  // Stall control and capture
  input wire logic [3:0] stall,
  output logic [96:0] last,
  output int acc_cnt
);
  logic [3:0] wait_ff;
  initial acc_cnt = 0;
  // Ready only after the stall count, so slow hosts are exercised
  always @(negedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ready <= 1'b0;
      wait_ff <= 4'h0;
    end else if (!valid) begin
      ready <= 1'b0;
      wait_ff <= 4'h0;
    end else if (!ready && wait_ff >= stall) begin
      ready <= 1'b1;
    end else if (!ready) begin
      wait_ff <= wait_ff + 4'h1;
    end
  end
  // Capture at the accepting edge only
  always @(posedge clk) begin
    if (valid && ready) begin
      last <= {addr64, addr, data};
      acc_cnt <= acc_cnt + 1;
    end
  end
endmodule

// File: sim/testbench.sv
`timescale 1ns/1ns
module testbench;
  logic clk = 0;
  logic rst_n = 0;
  logic pci_clk = 0;
  logic clock_range_select = 1;
  logic fast_speed_enable = 1;
  logic [15:0] irq = 16'h0000;
  logic frame = 0;
  logic [7:0] addr = 8'h00;
  logic [3:0] be = 4'h0;
  logic wr = 0;
  logic rd = 0;
  logic [31:0] wdata = 32'h0;
  logic [3:0] stall = 4'h0;
  wire logic [31:0] rdata;
  wire logic rvalid;
  wire logic vld;
  wire logic rdy;
  wire logic a64;
  wire logic [63:0] maddr;
  wire logic [31:0] mdata;
  wire logic [6:0] gclk;
  wire logic [96:0] last;
  int acc;
  int err_count = 0;
  int compares = 0;
  int cyc = 0;
  // ----------------------------------------------------------------------
  // Clocks, design and far side
  // ----------------------------------------------------------------------
  always #4 clk = ~clk;
  // Link clock offset so its edges never line up with the core clock
  initial #3 forever #24 pci_clk = ~pci_clk;
  pcb_top uut (.clk(clk), .rst_n(rst_n), .pci_clk(pci_clk),
    .clock_range_select(clock_range_select),
    .fast_speed_enable(fast_speed_enable), .irq_sample_pin(irq),
    .irq_frame_pin(frame), .cfg_addr(addr), .cfg_be(be), .cfg_wr(wr),
    .cfg_rd(rd), .cfg_wdata(wdata), .cfg_rdata(rdata),
    .cfg_rvalid(rvalid), .msi_req_valid(vld), .msi_req_ready(rdy),
    .msi_req_addr64(a64), .msi_req_addr(maddr), .msi_req_data(mdata),
    .generated_clock_outputs(gclk));
  pcb_up_model host (.clk(clk), .rst_n(rst_n), .valid(vld), .addr64(a64),
    .addr(maddr), .data(mdata), .ready(rdy), .stall(stall), .last(last),
    .acc_cnt(acc));
  // ----------------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------------
  task automatic check(input logic [63:0] got, input logic [63:0] exp);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic conclude();
    $display("mismatches=%0d compares=%0d", err_count, compares);
    if (err_count == 0 && compares > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [3:0] b,
                        input logic [31:0] d);
    @(negedge clk);
    addr = a;
    be = b;
    wdata = d;
    wr = 1'b1;
    @(negedge clk);
    wr = 1'b0;
  endtask
  // A missing valid pulse turns the data unknown so the compare fails
  task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
    @(negedge clk);
    addr = a;
    rd = 1'b1;
    @(negedge clk);
    rd = 1'b0;
    d = (rvalid === 1'b1) ? rdata : 32'hxxxxxxxx;
  endtask
  // Clock cycles from one low sample to the next after a high phase
  task automatic period(input int b, output int n);
    int k;
    k = 0;
    n = 0;
    while (gclk[b] !== 1'b1 && k < 40) begin @(negedge clk); k++; end
    while (gclk[b] !== 1'b0 && k < 80) begin @(negedge clk); k++; end
    while (gclk[b] !== 1'b1 && n < 40) begin @(negedge clk); n++; end
    while (gclk[b] !== 1'b0 && n < 80) begin @(negedge clk); n++; end
  endtask
  // Level pulse on one interrupt; ok when exactly one request went out
  task automatic fire(input int n, output logic ok);
    int a0;
    int k;
    a0 = acc;
    k = 0;
    @(negedge clk);
    irq[n] = 1'b1;
    while (acc == a0 && k < 300) begin @(negedge clk); k++; end
    irq[n] = 1'b0;
    repeat (30) @(negedge clk);
    ok = (acc == a0 + 1);
  endtask
  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  task automatic t_reset();
    logic [31:0] d;
    rd_reg(8'hd8, d);
    check(d, 64'h7f);
    rd_reg(8'he0, d);
    check(d, 64'h0);
    rd_reg(8'h50, d);
    check(d, 64'h0);
    rd_reg(8'h10, d);
    check(d, 64'h0);
  endtask
  task automatic t_clocks();
    int half[4] = '{3, 1, 2, 1};
    int n;
    for (int i = 0; i < 4; i++) begin
      clock_range_select = i[1];
      fast_speed_enable = i[0];
      repeat (40) @(negedge clk);
      period(0, n);
      check(n, 2 * half[i]);
      period(6, n);
      check(n, 2 * half[i]);
    end
  endtask
  task automatic t_enables();
    logic [6:0] seen;
    logic [31:0] d;
    int n;
    wr_reg(8'hd8, 4'h1, 32'h0);
    repeat (10) @(negedge clk);
    seen = 7'h00;
    repeat (20) @(negedge clk) seen |= gclk;
    check(seen, 64'h0);
    wr_reg(8'hd8, 4'h1, 32'h40);
    repeat (10) @(negedge clk);
    seen = 7'h00;
    repeat (20) @(negedge clk) seen |= gclk;
    check(seen, 64'h40);
    period(6, n);
    check(n, 2);
    wr_reg(8'hd8, 4'h1, 32'h7f);
    rd_reg(8'hd8, d);
    check(d, 64'h7f);
  endtask
  task automatic t_map();
    int codes[8] = '{0, 1, 2, 3, 4, 5, 6, 7};
    int irqs[2] = '{15, 6};
    logic [31:0] d;
    logic [31:0] exp_d;
    logic ok;
    int cnt;
    wr_reg(8'h54, 4'hf, 32'h80001003);
    rd_reg(8'h54, d);
    check(d, 64'h80001000);
    wr_reg(8'h58, 4'hf, 32'h0);
    wr_reg(8'h5c, 4'h3, 32'h4ab0);
    foreach (codes[c]) begin
      cnt = (codes[c] > 4) ? 16 : (1 << codes[c]);
      wr_reg(8'h50, 4'h4, 32'h10000 | (codes[c] << 20));
      stall = c[3:0];
      foreach (irqs[i]) begin
        fire(irqs[i], ok);
        exp_d = 32'h4ab0 | (irqs[i] & (cnt - 1));
        check(ok, 64'h1);
        check(last[31:0], exp_d);
        check(last[96:32], {1'b0, 64'h80001000});
      end
    end
    wr_reg(8'h58, 4'hf, 32'h12);
    fire(2, ok);
    check(last[96:32], {1'b1, 32'h12, 32'h80001000});
    wr_reg(8'h58, 4'hf, 32'h0);
  endtask
  task automatic t_off();
    logic [31:0] d;
    logic ok;
    int a0;
    wr_reg(8'h50, 4'h4, 32'h0);
    a0 = acc;
    irq[9] = 1'b1;
    repeat (40) @(negedge clk);
    rd_reg(8'he4, d);
    check(d, 64'h200);
    fire(4, ok);
    irq[9] = 1'b0;
    check(acc - a0, 64'h0);
  endtask
  task automatic t_edge();
    logic [31:0] d;
    int a0;
    wr_reg(8'h50, 4'h4, 32'h410000);
    wr_reg(8'he0, 4'hc, 32'h00080000);
    rd_reg(8'he0, d);
    check(d, 64'h00080000);
    repeat (40) @(negedge clk);
    a0 = acc;
    irq[3] = 1'b1;
    repeat (60) @(negedge clk);
    check(acc - a0, 64'h0);
    repeat (2) begin
      frame = 1'b1;
      repeat (20) @(negedge clk);
      frame = 1'b0;
      repeat (40) @(negedge clk);
    end
    check(acc - a0, 64'h1);
    check(last[31:0], 32'h4ab3);
    irq[3] = 1'b0;
  endtask
  // ----------------------------------------------------------------------
  // Watchdog and main sequence
  // ----------------------------------------------------------------------
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      conclude();
    end
  end
  initial begin
    repeat (8) @(negedge clk);
    rst_n = 1'b1;
    t_reset();
    t_clocks();
    t_enables();
    t_map();
    t_off();
    t_edge();
    conclude();
  end
endmodule
